// ===== src/mode_five_regs.svh
// Purpose: constants for the mode register five control block
// Assumes: command/address pins already decoded into a 22-bit mode word
// Notes: bit positions are those of the mode word
// How it works
// - with latency on, command sampled programmed clocks after chip select low.
// - max power saving ignores all commands except its exit and reset, but a parity error on one still sets bit 4.
// - mode set with select bits 20:18 equal 101 loads register five.
// - bit 12 enables read inversion, bit 11 write inversion.
// - multipurpose readout is never inverted.
// - bit 10 enables write byte mask, for writes only.
// - mask, inversion and termination strobe share one pin, chosen by mode.
// - without persistent mode, parity checking stops while the parity flag is set.
// - bits 8:6 select parked termination, 000 off.
// - bit 5 set ignores ODT in power-down, no nominal termination.
// - parity error sets bit 4, sticky until a mode set clears it.
// - CRC error sets bit 3, sticky until a mode set clears it.
// - bits 2:0 give parity latency 0,4,5,6; higher codes reserved.
// - register four bits 8:6 give command latency 0,3,4,5,6,8.
// - register four bit 1 enables max power saving mode.
// - with parity on and persistent mode or a clear parity flag, commands execute only without parity error.
`ifndef MODE_FIVE_REGS_SVH
`define MODE_FIVE_REGS_SVH
`define MR_SEL_HI 20
`define MR_SEL_LO 18
`define MR_SEL_FOUR 3'h4
`define MR_SEL_FIVE 3'h5
`define FIVE_RESET 22'h000000
`define FOUR_RESET 22'h000000
`define FIVE_RD_INV 12
`define FIVE_WR_INV 11
`define FIVE_MASK 10
`define FIVE_PERSIST 9
`define FIVE_PARK_HI 8
`define FIVE_PARK_LO 6
`define FIVE_ODT_OFF 5
`define FIVE_PAR_ERR 4
`define FIVE_CRC_ERR 3
`define FIVE_PLAT_HI 2
`define FIVE_PLAT_LO 0
`define FOUR_CAL_HI 8
`define FOUR_CAL_LO 6
`define FOUR_MPS 1
`endif

// ===== src/mode_five_pkg.sv
// Purpose: types for the mode register five control block
// Assumes: nothing
// Notes: shared-pin function encoding
package mode_five_pkg;
   typedef enum logic [1:0] {
      PIN_NONE = 2'b00,
      PIN_MASK = 2'b01,
      PIN_INV = 2'b10,
      PIN_TERM = 2'b11
   } pin_func_e;
   typedef struct packed {
      logic read_inv;
      logic write_inv;
      logic byte_mask;
      logic [2:0] park_code;
      logic odt_ignore;
      logic [2:0] parity_lat;
      logic [3:0] cal_lat;
   } mode_cfg_s;
endpackage

// ===== src/mode_five_ctrl.sv
// Purpose: mode register five decode, sticky error flags, latency and power modes
// Assumes: command pins synchronous to clk_sys_in; parity and CRC checks done outside
// Notes: outputs are registered, so cmd_valid_out lags a command by one cycle and the register views by two
`timescale 1ns/10ps
`include "mode_five_regs.svh"
`default_nettype none
module mode_five_ctrl
   import mode_five_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic cs_n_in,
   input wire logic ras_n_in,
   input wire logic cas_n_in,
   input wire logic we_n_in,
   input wire logic act_n_in,
   input wire logic [21:0] mode_word_in,
   input wire logic mps_exit_in,
   input wire logic parity_err_in,
   input wire logic crc_err_in,
   input wire logic readout_in,
   input wire logic term_strobe_in,
   input wire logic power_down_in,
   input wire logic odt_in,
   output logic cmd_valid_out,
   output logic [21:0] cmd_word_out,
   output logic mps_active_out,
   output logic parity_check_out,
   output logic nominal_term_out,
   output logic read_inv_out,
   output var mode_cfg_s cfg_out,
   output var pin_func_e pin_func_out,
   output logic [21:0] mode_five_out
);
   logic [21:0] mode_five_q;
   logic [21:0] mode_four_q;
   logic [7:0] cs_pipe_q;
   logic [21:0] word_pipe_q [0:7];
   logic [3:0] cal_lat;
   logic [2:0] par_lat;
   logic samp_now;
   logic [21:0] samp_word;
   logic is_mrs;
   logic par_on;
   logic par_ok;
   logic par_fault;

   function automatic logic [3:0] cal_decode(input logic [2:0] code);
      case (code)
         3'h1: cal_decode = 4'h3;
         3'h2: cal_decode = 4'h4;
         3'h3: cal_decode = 4'h5;
         3'h4: cal_decode = 4'h6;
         3'h5: cal_decode = 4'h8;
         default: cal_decode = 4'h0;
      endcase
   endfunction

   function automatic logic [2:0] par_decode(input logic [2:0] code);
      case (code)
         3'h1: par_decode = 3'h4;
         3'h2: par_decode = 3'h5;
         3'h3: par_decode = 3'h6;
         default: par_decode = 3'h0;
      endcase
   endfunction

   // select field match, shared by both register loads and the load check
   function automatic logic sel_hit(input logic [21:0] word, input logic [2:0] sel);
      sel_hit = (word[`MR_SEL_HI:`MR_SEL_LO] == sel);
   endfunction

   assign cal_lat = cal_decode(mode_four_q[`FOUR_CAL_HI:`FOUR_CAL_LO]);
   assign par_lat = par_decode(mode_five_q[`FIVE_PLAT_HI:`FIVE_PLAT_LO]);
   assign par_on = (par_lat != 3'h0);

   // delayed sampling; pipeline index 0 is one clock after chip select
   assign samp_now = (cal_lat == 4'h0) ? !cs_n_in : cs_pipe_q[3'(cal_lat - 4'h1)];
   assign samp_word = (cal_lat == 4'h0) ? mode_word_in : word_pipe_q[3'(cal_lat - 4'h1)];

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cs_pipe_q <= 8'h00;
      end else begin
         cs_pipe_q <= {cs_pipe_q[6:0], !cs_n_in};
      end
   end

   // data path needs no reset; only the chip select pipe gates its use
   always_ff @(posedge clk_sys_in) begin
      word_pipe_q[0] <= mode_word_in;
      for (int i = 1; i < 8; i++) begin
         word_pipe_q[i] <= word_pipe_q[i-1];
      end
   end

   // strobes low marks a mode set
   assign is_mrs = samp_now && !act_n_in && !ras_n_in && !cas_n_in && !we_n_in;
   assign par_ok = par_on && (mode_five_q[`FIVE_PERSIST] || !mode_five_q[`FIVE_PAR_ERR]);
   assign par_fault = samp_now && par_ok && parity_err_in;

   // max power saving entry and exit
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         mps_active_out <= 1'b0;
      end else if (mps_active_out) begin
         if (mps_exit_in) begin
            mps_active_out <= 1'b0;
         end
      end else if (mode_four_q[`FOUR_MPS]) begin
         mps_active_out <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         mode_four_q <= `FOUR_RESET;
      end else if (mps_exit_in && mps_active_out) begin
         mode_four_q[`FOUR_MPS] <= 1'b0;
      end else if (is_mrs && !par_fault && !mps_active_out &&
                   sel_hit(samp_word, `MR_SEL_FOUR)) begin
         mode_four_q <= samp_word;
      end
   end

   // sticky flags, set wins over clear
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         mode_five_q <= `FIVE_RESET;
      end else begin
         if (is_mrs && !par_fault && !mps_active_out &&
             sel_hit(samp_word, `MR_SEL_FIVE)) begin
            mode_five_q <= samp_word;
         end
         if (par_fault) begin
            mode_five_q[`FIVE_PAR_ERR] <= 1'b1;
         end
         if (crc_err_in) begin
            mode_five_q[`FIVE_CRC_ERR] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cmd_valid_out <= 1'b0;
         cmd_word_out <= 22'h000000;
      end else begin
         cmd_valid_out <= samp_now && !par_fault && !mps_active_out;
         cmd_word_out <= samp_word;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cfg_out <= '0;
         pin_func_out <= PIN_NONE;
         read_inv_out <= 1'b0;
         nominal_term_out <= 1'b0;
         parity_check_out <= 1'b0;
         mode_five_out <= `FIVE_RESET;
      end else begin
         cfg_out.read_inv <= mode_five_q[`FIVE_RD_INV];
         cfg_out.write_inv <= mode_five_q[`FIVE_WR_INV];
         cfg_out.byte_mask <= mode_five_q[`FIVE_MASK];
         cfg_out.park_code <= mode_five_q[`FIVE_PARK_HI:`FIVE_PARK_LO];
         cfg_out.odt_ignore <= mode_five_q[`FIVE_ODT_OFF];
         cfg_out.parity_lat <= par_lat;
         cfg_out.cal_lat <= cal_lat;
         if (term_strobe_in) begin
            pin_func_out <= PIN_TERM;
         end else if (mode_five_q[`FIVE_MASK]) begin
            pin_func_out <= PIN_MASK;
         end else if (mode_five_q[`FIVE_WR_INV] || mode_five_q[`FIVE_RD_INV]) begin
            pin_func_out <= PIN_INV;
         end else begin
            pin_func_out <= PIN_NONE;
         end
         read_inv_out <= mode_five_q[`FIVE_RD_INV] && !readout_in;
         nominal_term_out <= odt_in && !(power_down_in && mode_five_q[`FIVE_ODT_OFF]);
         parity_check_out <= par_ok;
         mode_five_out <= mode_five_q;
      end
   end

   property p_par_sticky;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         par_fault |=> mode_five_q[`FIVE_PAR_ERR];
   endproperty
   a_par_sticky: assert property (p_par_sticky) else $error("parity flag not set");

   property p_crc_sticky;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         mode_five_q[`FIVE_CRC_ERR] && !(is_mrs && sel_hit(samp_word, `MR_SEL_FIVE))
            |=> mode_five_q[`FIVE_CRC_ERR];
   endproperty
   a_crc_sticky: assert property (p_crc_sticky) else $error("crc flag dropped");

   property p_mps_ignore;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         mps_active_out |=> !cmd_valid_out;
   endproperty
   a_mps_ignore: assert property (p_mps_ignore) else $error("command in power saving");

   property p_readout_noinv;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         readout_in |=> !read_inv_out;
   endproperty
   a_readout_noinv: assert property (p_readout_noinv) else $error("readout inverted");

   // watches the registered output, so a broken decode path from the flag shows up too
   property p_no_check;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         mode_five_q[`FIVE_PAR_ERR] && !mode_five_q[`FIVE_PERSIST] |=> !parity_check_out;
   endproperty
   a_no_check: assert property (p_no_check) else $error("parity checked while flagged");

   property p_odt_off;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         power_down_in && mode_five_q[`FIVE_ODT_OFF] |=> !nominal_term_out;
   endproperty
   a_odt_off: assert property (p_odt_off) else $error("nominal term in power-down");

   property p_load_five;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         is_mrs && !par_fault && !mps_active_out && !crc_err_in &&
         sel_hit(samp_word, `MR_SEL_FIVE) |=> mode_five_q == $past(samp_word);
   endproperty
   a_load_five: assert property (p_load_five) else $error("register five not loaded");

   property p_cal_delay;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         cal_lat == 4'h3 && !cs_n_in && $stable(cal_lat) ##3 $stable(cal_lat) |-> samp_now;
   endproperty
   a_cal_delay: assert property (p_cal_delay) else $error("latency sample missed");

   property p_par_lat;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
         mode_five_q[`FIVE_PLAT_HI:`FIVE_PLAT_LO] == 3'h2 |=> cfg_out.parity_lat == 3'h5;
   endproperty
   a_par_lat: assert property (p_par_lat) else $error("parity latency wrong");
endmodule
`default_nettype wire

// ===== verification/mode_five_host.sv
// Purpose: controller model issuing commands
// Assumes: launched just after a rising edge
// Notes: idle address bus shows the inverted last word
`timescale 1ns/10ps
`default_nettype none
module mode_five_host (
   input wire logic clk_sys_in,
   input wire logic cmd_valid_in,
   input wire logic [21:0] cmd_word_in,
   output logic cs_n_out,
   output logic [3:0] strobe_n_out,
   output logic [21:0] mode_word_out
);
   initial begin
      cs_n_out = 1'b1;
      strobe_n_out = 4'hf;
      mode_word_out = 22'h3fffff;
   end
   // n counts edges to acceptance, -1 when refused
   task automatic issue(input logic [2:0] sel, input logic [17:0] b, input logic mrs,
      output int n, output logic [21:0] seen);
      logic [21:0] w;
      w = {1'b0, sel, b};
      w[17] = 1'b0;
      w[13] = 1'b0;
      w[11] = w[11] & ~w[10];
      @(posedge clk_sys_in);
      cs_n_out <= 1'b0;
      strobe_n_out <= mrs ? 4'h0 : 4'hd;
      mode_word_out <= w;
      @(posedge clk_sys_in);
      cs_n_out <= 1'b1;
      n = -1;
      seen = 22'h0;
      for (int i = 1; i <= 20 && n < 0; i++) begin
         @(negedge clk_sys_in);
         if (cmd_valid_in === 1'b1) begin
            n = i;
            seen = cmd_word_in;
         end
      end
      @(posedge clk_sys_in);
      strobe_n_out <= 4'hf;
      mode_word_out <= ~w;
   endtask
endmodule
`default_nettype wire

// ===== verification/sdram_mode_reg5_control_test.sv
// Purpose: self-checking bench for the mode five block
// Assumes: 125 MHz clock, sync active-low reset
// Notes: expectations come from the field layout
`timescale 1ns/10ps
`default_nettype none
module sdram_mode_reg5_control_test;
   import mode_five_pkg::*;
   typedef struct packed {
      logic [17:0] bits;
      logic strap;
      pin_func_e pin;
   } row_s;
   // no gear-down here, so code 010 is legal
   row_s rows [8] = '{'{18'h01041, 1'b0, PIN_INV}, '{18'h009e3, 1'b0, PIN_INV},
      '{18'h00702, 1'b0, PIN_MASK}, '{18'h00702, 1'b1, PIN_TERM},
      '{18'h00080, 1'b0, PIN_NONE}, '{18'h000c0, 1'b0, PIN_NONE},
      '{18'h00140, 1'b0, PIN_NONE}, '{18'h00180, 1'b0, PIN_NONE}};
   int lat [6] = '{0, 3, 4, 5, 6, 8};
   int plat [4] = '{0, 4, 5, 6};
   logic clk_sys_in, rst_n_in, mps_exit_in, parity_err_in, crc_err_in, readout_in;
   logic term_strobe_in, power_down_in, odt_in, cs_n, cmd_valid, mps_active;
   logic parity_check, nominal_term, read_inv;
   logic [3:0] strobe_n;
   logic [21:0] mode_word, cmd_word, mode_five, seen;
   mode_cfg_s cfg;
   pin_func_e pin_func;
   int bad_count, cmp_count, n;
   mode_five_host h (.clk_sys_in(clk_sys_in), .cmd_valid_in(cmd_valid),
      .cmd_word_in(cmd_word), .cs_n_out(cs_n), .strobe_n_out(strobe_n),
      .mode_word_out(mode_word));
   mode_five_ctrl i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n),
      .ras_n_in(strobe_n[2]), .cas_n_in(strobe_n[1]), .we_n_in(strobe_n[0]),
      .act_n_in(strobe_n[3]), .mode_word_in(mode_word), .mps_exit_in(mps_exit_in),
      .parity_err_in(parity_err_in), .crc_err_in(crc_err_in), .readout_in(readout_in),
      .term_strobe_in(term_strobe_in), .power_down_in(power_down_in), .odt_in(odt_in),
      .cmd_valid_out(cmd_valid), .cmd_word_out(cmd_word), .mps_active_out(mps_active),
      .parity_check_out(parity_check), .nominal_term_out(nominal_term),
      .read_inv_out(read_inv), .cfg_out(cfg), .pin_func_out(pin_func),
      .mode_five_out(mode_five));
   task automatic chk(input logic [21:0] s, input logic [21:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic w(input int k);
      repeat (k) @(negedge clk_sys_in);
   endtask
   task automatic wr(input logic [2:0] sel, input logic [17:0] b);
      h.issue(sel, b, 1'b1, n, seen);
      chk(22'(n > 0), 22'h1);
      w(2);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      {rst_n_in, mps_exit_in, parity_err_in, crc_err_in, readout_in} = '0;
      {term_strobe_in, power_down_in, odt_in} = '0;
      bad_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clk_sys_in);
         term_strobe_in <= rows[i].strap;
         wr(3'h5, rows[i].bits);
         chk(seen, {4'h5, rows[i].bits});
         chk(mode_five, {4'h5, rows[i].bits});
         chk(22'(n), 22'h1);
         chk(22'(cfg.parity_lat), 22'(plat[rows[i].bits[1:0]]));
         chk(22'({cfg.read_inv, cfg.write_inv, cfg.byte_mask, read_inv}),
            22'({rows[i].bits[12:10], rows[i].bits[12]}));
         chk(22'({cfg.park_code, cfg.odt_ignore, parity_check}),
            22'({rows[i].bits[8:5], |rows[i].bits[2:0]}));
         chk(22'(pin_func), 22'(rows[i].pin));
      end
      $display("table done");
      @(posedge clk_sys_in);
      rst_n_in <= 1'b0;
      w(2);
      chk(mode_five, 22'h0);
      chk(22'({cfg, pin_func, mps_active}), 22'h0);
      @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      $display("reset done");
      wr(3'h5, 18'h01020);
      @(posedge clk_sys_in);
      readout_in <= 1'b1;
      // odt kept at a valid level
      odt_in <= 1'b1;
      power_down_in <= 1'b1;
      w(2);
      chk(22'({read_inv, nominal_term}), 22'h0);
      @(posedge clk_sys_in);
      {readout_in, power_down_in} <= 2'b00;
      w(2);
      chk(22'({read_inv, nominal_term}), 22'h3);
      $display("pins done");
      wr(3'h5, 18'h00001);
      @(posedge clk_sys_in);
      parity_err_in <= 1'b1;
      h.issue(3'h0, 18'h0, 1'b0, n, seen);
      parity_err_in <= 1'b0;
      crc_err_in <= 1'b1;
      @(posedge clk_sys_in);
      crc_err_in <= 1'b0;
      w(4);
      chk(22'({n < 0, mode_five[4:3], parity_check}), 22'he);
      wr(3'h5, 18'h00201);
      chk(22'({mode_five[4:3], parity_check}), 22'h1);
      @(posedge clk_sys_in);
      parity_err_in <= 1'b1;
      h.issue(3'h0, 18'h0, 1'b0, n, seen);
      parity_err_in <= 1'b0;
      w(2);
      chk(22'({n < 0, mode_five[4], parity_check}), 22'h7);
      wr(3'h5, 18'h0);
      $display("flags done");
      for (int c = 0; c < 6; c++) begin
         wr(3'h4, 18'(c << 6));
         h.issue(3'h5, 18'h0, 1'b1, n, seen);
         chk(22'(n), 22'(1 + lat[c]));
         chk(22'(cfg.cal_lat), 22'(lat[c]));
      end
      $display("latency done");
      wr(3'h4, 18'h00002);
      h.issue(3'h5, 18'h0, 1'b1, n, seen);
      chk(22'({mps_active, n < 0}), 22'h3);
      @(posedge clk_sys_in);
      mps_exit_in <= 1'b1;
      @(posedge clk_sys_in);
      mps_exit_in <= 1'b0;
      h.issue(3'h5, 18'h0, 1'b1, n, seen);
      chk(22'({mps_active, 8'(n)}), 22'h1);
      $display("power saving done");
      conclude();
   end
endmodule
`default_nettype wire
